// ---- design/ftp_pkg.sv ----
// constants and types for the frame trigger and periodic event block
// assumes one 250 MHz clock and a simple strobe register port
//
// Operation
// - read-only calibrated frame readout time in us
// - line delay is readout time over lines
// - free-running: trigger outputs next completed frame
// - on-demand: frame only on valid trigger
// - trigger off: internal nominal rate, all frames
// - trigger on: chosen source governs acquisition
// - selector offers frame start trigger kind
// - only configured source triggers, when enabled
// - line source uses first input line
// - two periodic events usable as sources
// - software command triggers immediately
// - rising edge valid; policy only for lines
// - selector picks generator for start/interval access
// - no events before counter reaches start
// - events spaced by interval in ns
// - counter runs; software clear returns zero
// - first event at start, then every interval
// - initial triggered frames may be suppressed
// - past start aligns to start plus N intervals
// - near start may fire then or next
// - new interval counts from previous event
// - start value schedules first event, repeating every interval
package ftp_pkg;
    localparam int CLK_MHZ = 250;
    localparam int NS_PER_CLK = 1000 / CLK_MHZ;
    localparam int NOMINAL_FPS = 30;
    localparam int NOMINAL_FRAME_NS = 1000000000 / NOMINAL_FPS;
    localparam int NOMINAL_FRAME_CYC = NOMINAL_FRAME_NS / NS_PER_CLK;
    localparam int IMAGE_LINES = 480;
    localparam logic [31:0] READOUT_US_DEFAULT = 32'h00008126;
    localparam int SETTLE_FRAMES = 2;

    localparam logic [7:0] OFS_READOUT = 8'h00;
    localparam logic [7:0] OFS_LINE_DELAY = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_COMMAND = 8'h0c;
    localparam logic [7:0] OFS_GEN_SELECT = 8'h10;
    localparam logic [7:0] OFS_START_LO = 8'h14;
    localparam logic [7:0] OFS_START_HI = 8'h18;
    localparam logic [7:0] OFS_INTERVAL = 8'h1c;
    localparam logic [7:0] OFS_TIME_LO = 8'h20;
    localparam logic [7:0] OFS_TIME_HI = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;

    localparam int CTL_ENABLE = 0;
    localparam int CTL_POLICY = 1;
    localparam int CTL_KIND = 2;
    localparam int CTL_ORIGIN_LSB = 4;
    localparam int CTL_EDGE = 6;
    localparam int CMD_SW_TRIG = 0;
    localparam int CMD_TIME_CLEAR = 1;
    localparam logic [31:0] INTERVAL_DEFAULT = 32'h0032dcd5;

    typedef enum logic [1:0] {ORIGIN_LINE, ORIGIN_EVENT_A, ORIGIN_EVENT_B, ORIGIN_SW} ftp_origin_type;
    typedef enum logic {CONTINUOUS_READOUT, REQUESTED_READOUT} ftp_policy_type;
    typedef enum logic {FRAME_START_TRIG, KIND_OTHER} ftp_kind_type;
    typedef enum logic {EDGE_UP, EDGE_OTHER} ftp_edge_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ftp_bus_type;

    typedef struct packed {
        logic [63:0] start;
        logic [31:0] interval;
        logic [63:0] next;
        logic        armed;
    } ftp_gen_type;
endpackage

// ---- design/ftp_frame_trigger.sv ----
// frame start trigger selection and two periodic timestamp event generators
// registers over a plain strobe port; the input line is asynchronous
`timescale 1ns/1ns
module ftp_frame_trigger
    import ftp_pkg::*;
#(
    parameter int        NOMINAL_CYC = NOMINAL_FRAME_CYC,
    parameter int        LINES       = IMAGE_LINES,
    parameter logic [31:0] READOUT_US = READOUT_US_DEFAULT
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire ftp_bus_type bus,
    output logic [31:0]      rdata,
    input  wire logic        input_line_one,
    output logic             frameStart,
    output logic             frameOutput
);
    if (LINES < 1 || NOMINAL_CYC < 2) begin : g_param_check
        $error("ftp_frame_trigger: bad parameters");
    end

    typedef struct packed {
        logic [1:0]     rstSync;
        logic [1:0]     lineSync;
        logic           linePrev;
        logic           enable;
        ftp_policy_type policy;
        ftp_kind_type   kind;
        ftp_origin_type origin;
        ftp_edge_type   edgePolicy;
        logic           genSel;
        ftp_gen_type    genA;
        ftp_gen_type    genB;
        logic [63:0]    timeNs;
        logic [31:0]    nominalCnt;
        logic [3:0]     settleCnt;
        logic           pending;
        logic           frameStart;
        logic           frameOutput;
        logic [31:0]    rdata;
        logic [1:0]     eventSeen;
        logic [1:0]     genFired;
    } ftp_state_type;

    ftp_state_type s_r;
    ftp_state_type s_nxt;
    logic          rstnInt;
    assign rstnInt = s_r.rstSync[1];

    // one generator step: fire when time reaches next, then advance next by the interval; a zero interval disarms
    function automatic ftp_gen_type gen_step(input ftp_gen_type g, input logic [63:0] t, output logic fire);
        ftp_gen_type r;
        r = g;
        fire = 1'b0;
        if (g.armed && t >= g.next) begin
            fire = 1'b1;
            r.next = g.next + {32'h0, g.interval};
            if (g.interval == 32'h0) begin
                r.armed = 1'b0;
            end
        end
        return r;
    endfunction

    function automatic ftp_gen_type gen_program(input ftp_gen_type g, input logic [63:0] t);
        ftp_gen_type r;
        logic [63:0] steps;
        r = g;
        r.armed = 1'b1;
        r.next = g.start;
        if (t > g.start && g.interval != 32'h0) begin
            steps = (t - g.start + {32'h0, g.interval} - 64'h1) / {32'h0, g.interval};
            r.next = g.start + steps * {32'h0, g.interval};
        end
        return r;
    endfunction

    // a new interval counts from the last event; a point already passed fires at once
    function automatic ftp_gen_type gen_retime(input ftp_gen_type g, input logic [31:0] iv,
                                               input logic [63:0] t, input logic fired);
        ftp_gen_type r;
        logic [63:0] due;
        r = g;
        due = 64'h0;
        r.interval = iv;
        if (fired && g.armed) begin
            due = g.next - {32'h0, g.interval} + {32'h0, iv};
            r.next = (due > t) ? due : t;
        end
        return r;
    endfunction

    always_comb begin
        logic fireA;
        logic fireB;
        logic lineEdge;
        logic swTrig;
        logic trig;
        logic nominalTick;
        logic [63:0] lineDelay;
        s_nxt = s_r;
        fireA = 1'b0;
        fireB = 1'b0;
        swTrig = 1'b0;
        lineEdge = 1'b0;
        trig = 1'b0;
        nominalTick = 1'b0;
        lineDelay = 64'h0;
        s_nxt.rstSync = {s_r.rstSync[0], 1'b1};
        s_nxt.lineSync = {s_r.lineSync[0], input_line_one};
        s_nxt.linePrev = s_r.lineSync[1];
        lineEdge = s_r.lineSync[1] && !s_r.linePrev && s_r.edgePolicy == EDGE_UP;
        s_nxt.frameStart = 1'b0;
        s_nxt.frameOutput = 1'b0;
        s_nxt.rdata = 32'h0;
        s_nxt.timeNs = s_r.timeNs + 64'(NS_PER_CLK);
        s_nxt.genA = gen_step(s_r.genA, s_r.timeNs, fireA);
        s_nxt.genB = gen_step(s_r.genB, s_r.timeNs, fireB);
        s_nxt.eventSeen = s_r.eventSeen | {fireB, fireA};
        s_nxt.genFired = s_r.genFired | {fireB, fireA};
        lineDelay = 64'(READOUT_US) * 64'd1000 / 64'(LINES);

        if (bus.wr) begin
            if (bus.addr == OFS_CONTROL) begin
                s_nxt.enable = bus.wdata[CTL_ENABLE];
                s_nxt.policy = ftp_policy_type'(bus.wdata[CTL_POLICY]);
                s_nxt.kind = ftp_kind_type'(bus.wdata[CTL_KIND]);
                s_nxt.origin = ftp_origin_type'(bus.wdata[CTL_ORIGIN_LSB +: 2]);
                s_nxt.edgePolicy = ftp_edge_type'(bus.wdata[CTL_EDGE]);
            end else if (bus.addr == OFS_COMMAND) begin
                swTrig = bus.wdata[CMD_SW_TRIG];
                if (bus.wdata[CMD_TIME_CLEAR]) begin
                    s_nxt.timeNs = 64'h0;
                    s_nxt.genA = gen_program(s_r.genA, 64'h0);
                    s_nxt.genB = gen_program(s_r.genB, 64'h0);
                    s_nxt.genFired = 2'b00;
                end
            end else if (bus.addr == OFS_GEN_SELECT) begin
                s_nxt.genSel = bus.wdata[0];
            end else if (bus.addr == OFS_START_LO) begin
                if (s_r.genSel) begin
                    s_nxt.genB.start[31:0] = bus.wdata;
                    s_nxt.genB = gen_program(s_nxt.genB, s_r.timeNs);
                    s_nxt.genFired[1] = 1'b0;
                end else begin
                    s_nxt.genA.start[31:0] = bus.wdata;
                    s_nxt.genA = gen_program(s_nxt.genA, s_r.timeNs);
                    s_nxt.genFired[0] = 1'b0;
                end
            end else if (bus.addr == OFS_START_HI) begin
                if (s_r.genSel) begin
                    s_nxt.genB.start[63:32] = bus.wdata;
                end else begin
                    s_nxt.genA.start[63:32] = bus.wdata;
                end
            end else if (bus.addr == OFS_INTERVAL) begin
                // a running generator moves its next event to one new interval after the last event
                if (s_r.genSel) begin
                    s_nxt.genB = gen_retime(s_nxt.genB, bus.wdata, s_r.timeNs, s_nxt.genFired[1]);
                end else begin
                    s_nxt.genA = gen_retime(s_nxt.genA, bus.wdata, s_r.timeNs, s_nxt.genFired[0]);
                end
            end
        end

        if (bus.rd) begin
            if (bus.addr == OFS_READOUT) begin
                s_nxt.rdata = READOUT_US;
            end else if (bus.addr == OFS_LINE_DELAY) begin
                s_nxt.rdata = lineDelay[31:0];
            end else if (bus.addr == OFS_CONTROL) begin
                s_nxt.rdata = {25'h0, s_r.edgePolicy, s_r.origin, 1'b0, s_r.kind, s_r.policy, s_r.enable};
            end else if (bus.addr == OFS_GEN_SELECT) begin
                s_nxt.rdata = {31'h0, s_r.genSel};
            end else if (bus.addr == OFS_START_LO) begin
                s_nxt.rdata = s_r.genSel ? s_r.genB.start[31:0] : s_r.genA.start[31:0];
            end else if (bus.addr == OFS_START_HI) begin
                s_nxt.rdata = s_r.genSel ? s_r.genB.start[63:32] : s_r.genA.start[63:32];
            end else if (bus.addr == OFS_INTERVAL) begin
                s_nxt.rdata = s_r.genSel ? s_r.genB.interval : s_r.genA.interval;
            end else if (bus.addr == OFS_TIME_LO) begin
                s_nxt.rdata = s_r.timeNs[31:0];
            end else if (bus.addr == OFS_TIME_HI) begin
                s_nxt.rdata = s_r.timeNs[63:32];
            end else if (bus.addr == OFS_STATUS) begin
                s_nxt.rdata = {26'h0, s_r.settleCnt, s_r.eventSeen};
                s_nxt.eventSeen = {fireB, fireA}; // read clears, new event wins
            end
        end

        case (s_r.origin)
            ORIGIN_LINE:    trig = lineEdge;
            ORIGIN_EVENT_A: trig = fireA;
            ORIGIN_EVENT_B: trig = fireB;
            default:        trig = swTrig;
        endcase
        trig = trig && s_r.enable && s_r.kind == FRAME_START_TRIG;

        nominalTick = s_r.nominalCnt == 32'(NOMINAL_CYC - 1);
        s_nxt.nominalCnt = nominalTick ? 32'h0 : s_r.nominalCnt + 32'h1;

        if (!s_r.enable || s_r.kind != FRAME_START_TRIG) begin
            s_nxt.frameStart = nominalTick;
            s_nxt.frameOutput = nominalTick;
            s_nxt.pending = 1'b0;
        end else if (s_r.policy == REQUESTED_READOUT) begin
            s_nxt.frameStart = trig;
            s_nxt.frameOutput = trig && s_r.settleCnt == 4'h0;
            if (trig && s_r.settleCnt != 4'h0) begin
                s_nxt.settleCnt = s_r.settleCnt - 4'h1;
            end
        end else begin
            s_nxt.frameStart = nominalTick;
            if (trig) begin
                s_nxt.pending = 1'b1;
            end
            if (nominalTick && (s_r.pending || trig)) begin
                s_nxt.pending = 1'b0;
                s_nxt.frameOutput = s_r.settleCnt == 4'h0;
                if (s_r.settleCnt != 4'h0) begin
                    s_nxt.settleCnt = s_r.settleCnt - 4'h1;
                end
            end
        end
        if (bus.wr && bus.addr == OFS_CONTROL && bus.wdata[CTL_ENABLE] && !s_r.enable) begin
            s_nxt.settleCnt = 4'(SETTLE_FRAMES);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.genA.interval <= INTERVAL_DEFAULT;
            s_r.genB.interval <= INTERVAL_DEFAULT;
            s_r.policy <= REQUESTED_READOUT;
        end else if (!rstnInt) begin
            s_r <= '0;
            s_r.rstSync <= s_nxt.rstSync;
            s_r.genA.interval <= INTERVAL_DEFAULT;
            s_r.genB.interval <= INTERVAL_DEFAULT;
            s_r.policy <= REQUESTED_READOUT;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign frameStart = s_r.frameStart;
    assign frameOutput = s_r.frameOutput;
endmodule

// ---- verification/ftp_frame_trigger_asserts.sv ----
// port checker for the frame trigger block, with its own copy of the control field
// assumes one clock; bound to every ftp_frame_trigger instance
`timescale 1ns/1ns
module ftp_frame_trigger_asserts
    import ftp_pkg::*;
#(
    parameter int          NOMINAL_CYC = NOMINAL_FRAME_CYC,
    parameter int          LINES       = IMAGE_LINES,
    parameter logic [31:0] READOUT_US  = READOUT_US_DEFAULT
) (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire ftp_bus_type bus,
    input wire logic [31:0] rdata,
    input wire logic        input_line_one,
    input wire logic        frameStart,
    input wire logic        frameOutput
);
    logic [6:0] ctl_r;
    logic [2:0] calm_r;
    logic       line_r;
    wire        cmdWr = bus.wr && bus.addr == OFS_COMMAND;
    wire        on    = ctl_r[CTL_ENABLE] && !ctl_r[CTL_KIND] && calm_r == 3'h7;
    wire        reqSw = on && ctl_r[CTL_POLICY] && ctl_r[5:4] == 2'h3;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // calm counts cycles since the last control write or line change
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_r  <= 7'h02;
            calm_r <= 3'h0;
            line_r <= 1'b0;
        end else begin
            line_r <= input_line_one;
            if (bus.wr && bus.addr == OFS_CONTROL) ctl_r <= bus.wdata[6:0];
            if ((bus.wr && bus.addr == OFS_CONTROL) || input_line_one != line_r) calm_r <= 3'h0;
            else if (calm_r != 3'h7) calm_r <= calm_r + 3'h1;
        end
    end
    property p_ro; bus.rd && bus.addr == OFS_READOUT |=> rdata == READOUT_US; endproperty
    a_ro: assert property (p_ro) else $error("readout value wrong");
    property p_ld; bus.rd && bus.addr == OFS_LINE_DELAY |=> rdata == 32'(READOUT_US * 1000 / LINES); endproperty
    a_ld: assert property (p_ld) else $error("line delay wrong");
    property p_tick; (bus.rd && bus.addr == OFS_TIME_LO) ##1 (bus.rd && bus.addr == OFS_TIME_LO)
        |=> rdata == $past(rdata) + 32'h4; endproperty
    a_tick: assert property (p_tick) else $error("time step wrong");
    property p_sw; cmdWr && bus.wdata[CMD_SW_TRIG] && reqSw |=> frameStart; endproperty
    a_sw: assert property (p_sw) else $error("software start missing");
    property p_nosw; cmdWr && bus.wdata[CMD_SW_TRIG] && on && ctl_r[1] && ctl_r[5:4] == 2'h0 |=> !frameStart; endproperty
    a_nosw: assert property (p_nosw) else $error("unselected start taken");
    property p_cont; on && !ctl_r[CTL_POLICY] && frameOutput |-> frameStart; endproperty
    a_cont: assert property (p_cont) else $error("output off tick");
    property p_off; !ctl_r[CTL_ENABLE] && calm_r == 3'h7 |-> frameStart == frameOutput; endproperty
    a_off: assert property (p_off) else $error("frame dropped while off");
    property p_req; reqSw && !$past(cmdWr) |-> !frameStart; endproperty
    a_req: assert property (p_req) else $error("start without trigger");
    property p_line; on && ctl_r[1] && ctl_r[5:4] == 2'h0 && $rose(input_line_one) |-> ##[1:8] frameStart; endproperty
    a_line: assert property (p_line) else $error("line edge missed");
    c_sw: cover property (reqSw && cmdWr);
    c_out: cover property (frameOutput);
    c_line: cover property (on && $rose(input_line_one));
endmodule

bind ftp_frame_trigger ftp_frame_trigger_asserts #(.NOMINAL_CYC(NOMINAL_CYC), .LINES(LINES), .READOUT_US(READOUT_US))
    i_ftp_frame_trigger_asserts (.sys_clk(sys_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .input_line_one(input_line_one), .frameStart(frameStart), .frameOutput(frameOutput));

// ---- verification/ftp_host_model.sv ----
// host application and trigger line driver on the far side of the block
// changes signals just after a rising edge; tb calls its tasks
`timescale 1ns/1ns
module ftp_host_model
    import ftp_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic [31:0] rdata,
    output ftp_bus_type      bus,
    output logic             input_line_one
);
    initial begin
        bus            = '0;
        input_line_one = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        @(negedge sys_clk);
        d = rdata;
    endtask
    // two reads with no gap between the strobes
    task automatic rd2(input logic [7:0] a, output logic [31:0] d0, output logic [31:0] d1);
        @(posedge sys_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge sys_clk);
        @(negedge sys_clk);
        d0 = rdata;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        @(negedge sys_clk);
        d1 = rdata;
    endtask
    // the source and enable are set before any trigger is sent
    task automatic set_ctl(input logic [6:0] c); wr(OFS_CONTROL, {25'h0, c}); endtask
    task automatic sw_trig(); wr(OFS_COMMAND, 32'h1); endtask
    task automatic line_pulse();
        @(posedge sys_clk);
        input_line_one <= 1'b1;
        repeat (6) @(posedge sys_clk);
        input_line_one <= 1'b0;
    endtask
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the frame trigger block
// host model drives the register port and line; checker comes in by bind
`timescale 1ns/1ns
module tb
    import ftp_pkg::*;
;
    localparam int NCYC = 100;
    logic        sysClk;
    logic        rstn;
    ftp_bus_type bus;
    logic [31:0] rdata;
    logic        inputLineOne;
    logic        frameStart;
    logic        frameOutput;
    int          errCount = 0;
    int          nCompared = 0;
    int          nStart = 0;
    int          nOut = 0;
    ftp_frame_trigger #(.NOMINAL_CYC(NCYC)) i_ftp_frame_trigger (.sys_clk(sysClk), .rstn(rstn), .bus(bus),
        .rdata(rdata), .input_line_one(inputLineOne), .frameStart(frameStart), .frameOutput(frameOutput));
    ftp_host_model host (.sys_clk(sysClk), .rdata(rdata), .bus(bus), .input_line_one(inputLineOne));
    initial begin
        sysClk = 1'b0;
        forever #2 sysClk = ~sysClk;
    end
    always @(negedge sysClk) begin
        if (frameStart === 1'b1) nStart++;
        if (frameOutput === 1'b1) nOut++;
    end
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_start(output int n);
        n = 0;
        do begin
            @(negedge sysClk);
            n++;
            if (n > 4 * NCYC) begin
                errCount++;
                print_verdict();
            end
        end while (frameStart !== 1'b1);
    endtask
    task automatic t_regs();
        logic [31:0] d;
        host.wr(OFS_READOUT, 32'h0);
        host.rd(OFS_READOUT, d);
        check(d, READOUT_US_DEFAULT);
        host.rd(OFS_LINE_DELAY, d);
        check(d, 32'(READOUT_US_DEFAULT * 1000 / IMAGE_LINES));
        host.rd(8'h3c, d);
        check(d, 32'h0);
        host.rd(OFS_CONTROL, d);
        check(d, 32'h2);
        host.wr(OFS_CONTROL, 32'h72);
        host.rd(OFS_CONTROL, d);
        check(d, 32'h72);
        $display("t_regs done");
    endtask
    task automatic t_trig();
        int s;
        int o;
        @(posedge sysClk);
        s = nStart;
        o = nOut;
        repeat (3 * NCYC) @(posedge sysClk);
        check(nStart - s, 3);
        check(nOut - o, 3);
        host.set_ctl(7'h33);
        repeat (8) @(posedge sysClk);
        s = nStart;
        o = nOut;
        repeat (3) host.sw_trig();
        repeat (4) @(posedge sysClk);
        check(nStart - s, 3);
        check(nOut - o, 1);
        host.set_ctl(7'h03);
        repeat (8) @(posedge sysClk);
        s = nStart;
        host.sw_trig();
        repeat (8) @(posedge sysClk);
        check(nStart - s, 0);
        host.line_pulse();
        repeat (10) @(posedge sysClk);
        check(nStart - s, 1);
        host.set_ctl(7'h31);
        repeat (8) @(posedge sysClk);
        o = nOut;
        host.sw_trig();
        repeat (NCYC + 4) @(posedge sysClk);
        check(nOut - o, 1);
        $display("t_trig done");
    endtask
    task automatic t_per();
        logic [31:0] d;
        logic [31:0] d2;
        int n;
        int s;
        host.set_ctl(7'h13);
        host.wr(OFS_INTERVAL, 32'h28);
        host.wr(OFS_COMMAND, 32'h2);
        host.rd2(OFS_TIME_LO, d, d2);
        check(d < 32'h20, 1);
        check(d2 - d, 32'h4);
        host.wr(OFS_START_HI, 32'h0);
        host.wr(OFS_START_LO, 32'h190);
        wait_start(n);
        check(n >= 88 && n <= 100, 1);
        wait_start(n);
        check(n, 10);
        host.wr(OFS_INTERVAL, 32'h50);
        wait_start(n);
        check(n, 19);
        wait_start(n);
        check(n, 20);
        host.set_ctl(7'h23);
        s = nStart;
        repeat (50) @(posedge sysClk);
        check(nStart - s, 0);
        host.wr(OFS_GEN_SELECT, 32'h1);
        host.wr(OFS_INTERVAL, 32'h28);
        host.wr(OFS_START_LO, 32'h0);
        wait_start(n);
        check(n <= 11, 1);
        $display("t_per done");
    endtask
    initial begin
        rstn = 1'b0;
        repeat (12) @(posedge sysClk);
        rstn <= 1'b1;
        repeat (3) @(posedge sysClk);
        t_regs();
        t_trig();
        t_per();
        print_verdict();
    end
endmodule
